// ---- coproc_arith_pkg.sv ----
// Constants shared by the coprocessor arithmetic decode and execute logic.
// Assumes a 32-bit coprocessor instruction word arriving from the host core.
package coproc_arith_pkg;
    // Instruction field positions (lsb of each field)
    localparam int FLD_CLASS_LSB = 24;
    localparam int FLD_RSVD_LSB  = 22;
    localparam int FLD_SZ_LSB    = 20;
    localparam int FLD_SRC_A_LSB = 16;
    localparam int FLD_DEST_LSB  = 12;
    localparam int FLD_GRP_LSB   = 8;
    localparam int FLD_OPC_LSB   = 5;
    localparam int FLD_ZERO_BIT  = 4;
    localparam int FLD_SRC_B_LSB = 0;
    // Fixed field codes
    localparam logic [3:0] CLASS_CODE = 4'he;
    localparam logic [1:0] RSVD_CODE  = 2'h0;
    localparam logic [3:0] GRP_FP     = 4'h4;
    localparam logic [3:0] GRP_INT    = 4'h5;
    localparam logic [3:0] GRP_ACC    = 4'h6;
    localparam logic [1:0] SZ_ADDSUB  = 2'h3;
    localparam logic [1:0] SZ_MUL     = 2'h1;
    localparam logic [1:0] ACC_MADD   = 2'h0;
    localparam logic [1:0] ACC_MSUB   = 2'h1;
    localparam logic [1:0] ACC_MADDA  = 2'h2;
    localparam logic [1:0] ACC_MSUBA  = 2'h3;
    // Storage sizes and reset values
    localparam int          NUM_REGS  = 16;
    localparam int          NUM_ACCS  = 8;
    localparam logic [63:0] REG_RESET = 64'h0;
    localparam logic [31:0] ACC_RESET = 32'h0;
    // Floating point exponent constants
    localparam logic signed [12:0] EXP_BIAS  = 13'sh3ff;
    localparam logic [10:0]        EXP_SHIFT = 11'h380;
    localparam logic [10:0]        SGL_OVF   = 11'h47f;
    // Decoded operations
    typedef enum logic [4:0] {
        OP_NONE          = 5'b00000,
        OP_FP_SINGLE_SUB = 5'b00001,
        OP_FP_DOUBLE_SUB = 5'b00010,
        OP_FP_SINGLE_MUL = 5'b00011,
        OP_FP_DOUBLE_MUL = 5'b00100,
        OP_INT32_ABS     = 5'b00101,
        OP_INT64_ABS     = 5'b00110,
        OP_INT32_NEG     = 5'b00111,
        OP_INT64_NEG     = 5'b01000,
        OP_INT32_ADD     = 5'b01001,
        OP_INT64_ADD     = 5'b01010,
        OP_INT32_SUB     = 5'b01011,
        OP_INT64_SUB     = 5'b01100,
        OP_INT32_MUL     = 5'b01101,
        OP_INT64_MUL     = 5'b01110,
        OP_INT32_MAC     = 5'b01111,
        OP_INT32_MDED    = 5'b10000,
        OP_ACC_MADD_REG  = 5'b10001,
        OP_ACC_MSUB_REG  = 5'b10010,
        OP_ACC_MADD_ACC  = 5'b10011,
        OP_ACC_MSUB_ACC  = 5'b10100
    } op_e;
endpackage

// ---- coprocessor_arith_decode.sv ----
// Decode and single-cycle execute of the coprocessor arithmetic subset.
// Assumes the host core has already checked the condition field and
// offers one instruction per cycle; a load port fills registers.
`timescale 1ns/1ps

module coprocessor_arith_decode
    import coproc_arith_pkg::*;
(
    input  wire logic        sys_clk,        // Core clock
    input  wire logic        rst_n,          // Synchronous reset, active low
    input  wire logic        instr_valid,    // Instruction offered this cycle
    input  wire logic [31:0] instr,          // Instruction word
    output logic             instr_accept,   // Instruction taken and executed
    output logic             instr_undef,    // Instruction not of this subset
    input  wire logic        load_en,        // Load a register from the core
    input  wire logic [3:0]  load_idx,       // Register to load
    input  wire logic [63:0] load_data,      // Value to load
    input  wire logic [3:0]  read_idx,       // Register to read
    output logic [63:0]      read_data,      // Register value, one cycle later
    input  wire logic [2:0]  acc_read_idx,   // Accumulator to read
    output logic [31:0]      acc_read_data   // Accumulator value, one cycle later
);
    // Whole block state
    typedef struct packed {
        logic [NUM_REGS-1:0][63:0] regs;
        logic [NUM_ACCS-1:0][31:0] accs;
        logic [63:0]               rd;
        logic [31:0]               acc_rd;
    } state_s;

    state_s      st_q;       // Registered state
    state_s      st_d;       // Next state
    op_e         op;         // Decoded operation
    logic [3:0]  src_a;      // First source register number
    logic [3:0]  src_b;      // Second source register number
    logic [3:0]  dst;        // Destination or addend register number
    logic [2:0]  acc_sel;    // Destination accumulator
    logic [63:0] sa;         // First source value
    logic [63:0] sb;         // Second source value
    logic [63:0] sd;         // Destination prior value
    logic [31:0] sacc;       // Source accumulator value
    logic [31:0] prod32;     // Low word of the 32-bit product
    logic        base_ok;    // Fixed fields match

    // Double precision multiply; zero and denormal inputs flush to zero,
    // rounding truncates to keep the datapath single-cycle.
    function automatic logic [63:0] fp_mul(input logic [63:0] a, input logic [63:0] b);
        logic [105:0]      p;
        logic signed [12:0] e;
        logic              s;
        s = a[63] ^ b[63];
        p = {1'b1, a[51:0]} * {1'b1, b[51:0]};
        e = $signed({2'h0, a[62:52]}) + $signed({2'h0, b[62:52]}) - EXP_BIAS;
        if (p[105]) begin
            p = p >> 1;
            e = e + 13'sh1;
        end
        if (a[62:52] == 11'h0 || b[62:52] == 11'h0 || e <= 13'sh0) begin
            fp_mul = {s, 63'h0};
        end else if (e >= 13'sh7ff) begin
            fp_mul = {s, 11'h7ff, 52'h0};
        end else begin
            fp_mul = {s, e[10:0], p[103:52]};
        end
    endfunction

    // Double precision add; larger magnitude first so the result sign is its sign
    function automatic logic [63:0] fp_add(input logic [63:0] a, input logic [63:0] b);
        logic [63:0] x;
        logic [63:0] y;
        logic [10:0] d;
        logic [10:0] e;
        logic [54:0] mx;
        logic [54:0] my;
        logic [54:0] r;
        if (a[62:0] >= b[62:0]) begin
            x = a;
            y = b;
        end else begin
            x = b;
            y = a;
        end
        e  = x[62:52];
        d  = x[62:52] - y[62:52];
        mx = {2'h1, x[51:0], 1'b0};
        my = (y[62:52] == 11'h0 || d > 11'h36) ? 55'h0 : ({2'h1, y[51:0], 1'b0} >> d);
        r  = (x[63] == y[63]) ? mx + my : mx - my;
        if (r[54]) begin
            r = r >> 1;
            e = e + 11'h1;
        end
        // Cancellation: shift left until the hidden bit is back
        for (int k = 0; k < 54; k++) begin
            if (!r[53] && e > 11'h1) begin
                r = r << 1;
                e = e - 11'h1;
            end
        end
        if (x[62:52] == 11'h0 || !r[53]) begin
            fp_add = 64'h0;
        end else if (e == 11'h7ff) begin
            fp_add = {x[63], 11'h7ff, 52'h0};
        end else begin
            fp_add = {x[63], e, r[52:1]};
        end
    endfunction

    // Widen single to double, exact for normal values; zero and denormal inputs flush to zero
    function automatic logic [63:0] s2d(input logic [31:0] f);
        if (f[30:23] == 8'h0) begin
            s2d = {f[31], 63'h0};
        end else if (f[30:23] == 8'hff) begin
            s2d = {f[31], 11'h7ff, f[22:0], 29'h0};
        end else begin
            s2d = {f[31], 11'(f[30:23]) + EXP_SHIFT, f[22:0], 29'h0};
        end
    endfunction

    // Narrow double to single; underflow flushes, overflow saturates to infinity
    function automatic logic [31:0] d2s(input logic [63:0] v);
        logic [10:0] e;
        e = v[62:52];
        if (e <= EXP_SHIFT) begin
            d2s = {v[63], 31'h0};
        end else if (e >= SGL_OVF) begin
            d2s = {v[63], 8'hff, 23'h0};
        end else begin
            d2s = {v[63], 8'(e - EXP_SHIFT), v[51:29]};
        end
    endfunction

    // Operand fields and operand fetch
    assign src_a   = instr[FLD_SRC_A_LSB +: 4];
    assign dst     = instr[FLD_DEST_LSB +: 4];
    assign src_b   = instr[FLD_SRC_B_LSB +: 4];
    assign acc_sel = instr[FLD_OPC_LSB +: 3];
    assign sa      = st_q.regs[src_a];
    assign sb      = st_q.regs[src_b];
    assign sd      = st_q.regs[dst];
    assign sacc    = st_q.accs[dst[2:0]];
    assign prod32  = 32'(sa[31:0] * sb[31:0]);

    // Fixed fields; bit four set marks a different instruction family
    assign base_ok = instr[FLD_CLASS_LSB +: 4] == CLASS_CODE
                  && instr[FLD_RSVD_LSB +: 2] == RSVD_CODE
                  && !instr[FLD_ZERO_BIT];

    // Decode; anything outside the subset leaves OP_NONE
    always_comb begin
        op = OP_NONE;
        if (base_ok) begin
            case (instr[FLD_GRP_LSB +: 4])
                GRP_FP: begin
                    // Size bits 21:20 and opcode bits 7:5 are not adjacent
                    case ({instr[FLD_SZ_LSB +: 2], instr[FLD_OPC_LSB +: 3]})
                        {SZ_ADDSUB, 3'h6}: op = OP_FP_SINGLE_SUB;
                        {SZ_ADDSUB, 3'h7}: op = OP_FP_DOUBLE_SUB;
                        {SZ_MUL, 3'h0}:    op = OP_FP_SINGLE_MUL;
                        {SZ_MUL, 3'h1}:    op = OP_FP_DOUBLE_MUL;
                        default:           op = OP_NONE;
                    endcase
                end
                GRP_INT: begin
                    // Rows follow the opcode in bits 7:5
                    case ({instr[FLD_SZ_LSB +: 2], instr[FLD_OPC_LSB +: 3]})
                        {SZ_ADDSUB, 3'h0}: op = OP_INT32_ABS;
                        {SZ_ADDSUB, 3'h1}: op = OP_INT64_ABS;
                        {SZ_ADDSUB, 3'h2}: op = OP_INT32_NEG;
                        {SZ_ADDSUB, 3'h3}: op = OP_INT64_NEG;
                        {SZ_ADDSUB, 3'h4}: op = OP_INT32_ADD;
                        {SZ_ADDSUB, 3'h5}: op = OP_INT64_ADD;
                        {SZ_ADDSUB, 3'h6}: op = OP_INT32_SUB;
                        {SZ_ADDSUB, 3'h7}: op = OP_INT64_SUB;
                        {SZ_MUL, 3'h0}:    op = OP_INT32_MUL;
                        {SZ_MUL, 3'h1}:    op = OP_INT64_MUL;
                        {SZ_MUL, 3'h2}:    op = OP_INT32_MAC;
                        {SZ_MUL, 3'h3}:    op = OP_INT32_MDED;
                        default:           op = OP_NONE;
                    endcase
                end
                GRP_ACC: begin
                    // Every accumulator form is legal; bits 7:5 only pick a target
                    case (instr[FLD_SZ_LSB +: 2])
                        ACC_MADD:  op = OP_ACC_MADD_REG;
                        ACC_MSUB:  op = OP_ACC_MSUB_REG;
                        ACC_MADDA: op = OP_ACC_MADD_ACC;
                        ACC_MSUBA: op = OP_ACC_MSUB_ACC;
                        default:   op = OP_NONE;
                    endcase
                end
                default: op = OP_NONE;
            endcase
        end
    end

    // Handshake is combinational so the core learns the verdict in the issue cycle
    assign instr_accept = instr_valid && (op != OP_NONE);
    assign instr_undef  = instr_valid && (op == OP_NONE);

    // Next state: load first, then an accepted instruction overrides the same slot.
    // 32-bit and single results are zero-extended into the 64-bit register.
    always_comb begin
        st_d        = st_q;
        st_d.rd     = st_q.regs[read_idx];
        st_d.acc_rd = st_q.accs[acc_read_idx];
        if (load_en) begin
            st_d.regs[load_idx] = load_data;
        end
        if (instr_accept) begin
            case (op)
                OP_FP_SINGLE_SUB: st_d.regs[dst] = {32'h0, d2s(fp_add(s2d(sa[31:0]),
                                      s2d({~sb[31], sb[30:0]})))};
                OP_FP_DOUBLE_SUB: st_d.regs[dst] = fp_add(sa, {~sb[63], sb[62:0]});
                OP_FP_SINGLE_MUL: st_d.regs[dst] = {32'h0,
                                      d2s(fp_mul(s2d(sa[31:0]), s2d(sb[31:0])))};
                OP_FP_DOUBLE_MUL: st_d.regs[dst] = fp_mul(sa, sb);
                OP_INT32_ABS: st_d.regs[dst] = {32'h0, sa[31] ? 32'h0 - sa[31:0] : sa[31:0]};
                OP_INT64_ABS: st_d.regs[dst] = sa[63] ? 64'h0 - sa : sa;
                OP_INT32_NEG: st_d.regs[dst] = {32'h0, 32'h0 - sa[31:0]};
                OP_INT64_NEG: st_d.regs[dst] = 64'h0 - sa;
                OP_INT32_ADD: st_d.regs[dst] = {32'h0, sa[31:0] + sb[31:0]};
                OP_INT64_ADD: st_d.regs[dst] = sa + sb;
                OP_INT32_SUB: st_d.regs[dst] = {32'h0, sa[31:0] - sb[31:0]};
                OP_INT64_SUB: st_d.regs[dst] = sa - sb;
                OP_INT32_MUL: st_d.regs[dst] = {32'h0, prod32};
                OP_INT64_MUL: st_d.regs[dst] = 64'(sa * sb);
                OP_INT32_MAC: st_d.regs[dst] = {32'h0, sd[31:0] + prod32};
                OP_INT32_MDED: st_d.regs[dst] = {32'h0, sd[31:0] - prod32};
                OP_ACC_MADD_REG: st_d.accs[acc_sel] = sd[31:0] + prod32;
                OP_ACC_MSUB_REG: st_d.accs[acc_sel] = sd[31:0] - prod32;
                OP_ACC_MADD_ACC: st_d.accs[acc_sel] = sacc + prod32;
                OP_ACC_MSUB_ACC: st_d.accs[acc_sel] = sacc - prod32;
                default: st_d.regs[dst] = st_q.regs[dst];
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q.regs   <= {NUM_REGS{REG_RESET}};
            st_q.accs   <= {NUM_ACCS{ACC_RESET}};
            st_q.rd     <= REG_RESET;
            st_q.acc_rd <= ACC_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign read_data     = st_q.rd;
    assign acc_read_data = st_q.acc_rd;

    // Checks on the decode and the executed results
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_take(op_e o);
        instr_accept && op == o;
    endsequence

    AST_FP_SUB_DECODE: assert property (instr_valid && instr[27:20] == 8'he3
        && instr[11:4] == 8'h4c |-> instr_accept && op == OP_FP_SINGLE_SUB)
        else $error("single sub not decoded");
    AST_FP_DSUB_DECODE: assert property (instr_valid && instr[27:20] == 8'he3
        && instr[11:4] == 8'h4e |-> op == OP_FP_DOUBLE_SUB)
        else $error("double sub not decoded");
    AST_FP_MUL_DECODE: assert property (instr_valid && instr[27:20] == 8'he1
        && instr[11:4] == 8'h40 |-> op == OP_FP_SINGLE_MUL) else $error("single mul bad");
    AST_INT32_ABS: assert property (s_take(OP_INT32_ABS) ##1 !$past(load_en)
        |-> st_q.regs[$past(dst)][31] == 1'b0 || $past(sa[31:0]) == 32'h80000000)
        else $error("abs32 negative");
    AST_INT64_NEG: assert property (s_take(OP_INT64_NEG)
        |=> st_q.regs[$past(dst)] + $past(sa) == 64'h0) else $error("neg64 wrong");
    AST_INT32_ADD: assert property (s_take(OP_INT32_ADD)
        |=> st_q.regs[$past(dst)] == {32'h0, $past(sa[31:0]) + $past(sb[31:0])})
        else $error("add32 wrong");
    AST_INT64_SUB: assert property (s_take(OP_INT64_SUB)
        |=> st_q.regs[$past(dst)] + $past(sb) == $past(sa)) else $error("sub64 wrong");
    AST_INT32_MAC: assert property (s_take(OP_INT32_MAC)
        |=> st_q.regs[$past(dst)][31:0] == $past(sd[31:0]) + $past(prod32))
        else $error("mac32 wrong");
    AST_ACC_MSUB: assert property (s_take(OP_ACC_MSUB_ACC)
        |=> st_q.accs[$past(acc_sel)] + $past(prod32) == $past(sacc))
        else $error("acc msub wrong");
    AST_BIT4_SET: assert property (instr_valid && instr[4] |-> instr_undef && !instr_accept)
        else $error("bit four set accepted");
endmodule

// ---- coprocessor_arith_decode_tb_top.sv ----
// Self-checking bench for the coprocessor arithmetic decoder.
// Assumes the package and the host model are compiled before it.
`timescale 1ns/1ps
module coprocessor_arith_decode_tb_top;
    import coproc_arith_pkg::*;
    logic        sys_clk = 1'b0;       // 200 MHz core clock
    logic        rst_n = 1'b0;         // Synchronous reset
    logic        issue = 1'b0;         // Ask the host to send
    logic [31:0] word = 32'h0;         // Word for the host
    logic        cond_ok = 1'b1;       // Host condition result
    logic        instr_valid;          // Offer from host
    logic [31:0] instr;                // Word from host
    logic        instr_accept;         // Decoder took the word
    logic        instr_undef;          // Decoder refused the word
    logic        load_en = 1'b0;       // Register load strobe
    logic [3:0]  load_idx = 4'h0;      // Load target
    logic [63:0] load_data = 64'h0;    // Load value
    logic [3:0]  read_idx = 4'h0;      // Register read index
    logic [63:0] read_data;            // Register read value
    logic [2:0]  acc_read_idx = 3'h0;  // Accumulator read index
    logic [31:0] acc_read_data;        // Accumulator read value
    logic [63:0] regs_m [16];          // Expected registers
    logic [31:0] accs_m [8];           // Expected accumulators
    logic [3:0]  u, n, m, d;           // Random picks
    logic [31:0] w;                    // Word under test
    int          err_count = 0;        // Mismatches
    int          checks = 0;           // Comparisons
    int          seed = 32'hca5e;      // Fixed seed keeps runs repeatable
    // Float cases with exact results, so rounding never matters
    logic [4:0]  fo [4] = '{5'h1e, 5'h1f, 5'h08, 5'h09};
    logic [63:0] fa [4] = '{64'h3f800000, 64'h3ff8000000000000, 64'h3fc00000,
                            64'h3ff8000000000000};
    logic [63:0] fb [4] = '{64'h40400000, 64'h4008000000000000, 64'h40000000,
                            64'h4000000000000000};
    logic [63:0] fr [4] = '{64'hc0000000, 64'hbff8000000000000, 64'h40400000,
                            64'h4008000000000000};

    // Free-running core clock
    always #2.5 sys_clk = ~sys_clk;

    host_issue_model i_host (.sys_clk(sys_clk), .issue(issue), .word(word),
        .cond_ok(cond_ok), .instr_valid(instr_valid), .instr(instr));
    coprocessor_arith_decode i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr(instr), .instr_accept(instr_accept),
        .instr_undef(instr_undef), .load_en(load_en), .load_idx(load_idx),
        .load_data(load_data), .read_idx(read_idx), .read_data(read_data),
        .acc_read_idx(acc_read_idx), .acc_read_data(acc_read_data));

    // Counts and verdict; the only way the run ends
    task automatic give_verdict();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One comparison, reported at once on mismatch
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Instruction word with a fixed always-true condition code
    function automatic logic [31:0] mk(input logic [3:0] g, input logic [1:0] sz,
        input logic [2:0] op, input logic [3:0] fn, input logic [3:0] fd, input logic [3:0] fm);
        mk = {4'he, CLASS_CODE, RSVD_CODE, sz, fn, fd, g, op, 1'b0, fm};
    endfunction

    // Expected integer result for size and opcode bits together
    function automatic logic [63:0] int_res(input logic [4:0] so, input logic [63:0] a,
        input logic [63:0] b, input logic [63:0] r);
        logic [31:0] p;
        p = a[31:0] * b[31:0];
        case (so)
            5'h18: int_res = {32'h0, a[31] ? -a[31:0] : a[31:0]};
            5'h19: int_res = a[63] ? -a : a;
            5'h1a: int_res = {32'h0, -a[31:0]};
            5'h1b: int_res = -a;
            5'h1c: int_res = {32'h0, a[31:0] + b[31:0]};
            5'h1d: int_res = a + b;
            5'h1e: int_res = {32'h0, a[31:0] - b[31:0]};
            5'h1f: int_res = a - b;
            5'h08: int_res = {32'h0, p};
            5'h09: int_res = a * b;
            5'h0a: int_res = {32'h0, r[31:0] + p};
            default: int_res = {32'h0, r[31:0] - p};
        endcase
    endfunction

    // Every control changes once, just after a falling edge
    task automatic step(input logic iss, input logic [31:0] wd, input logic ld,
        input logic [3:0] idx, input logic [63:0] v);
        @(negedge sys_clk);
        issue = iss;
        word = wd;
        load_en = ld;
        load_idx = idx;
        load_data = v;
        read_idx = idx;
        acc_read_idx = idx[2:0];
    endtask

    // Register load through the side port
    task automatic load(input logic [3:0] i, input logic [63:0] v);
        step(1'b0, 32'h0, 1'b1, i, v);
        regs_m[i] = v;
    endtask

    // Read register i and accumulator i[2:0]; data lands one edge later
    task automatic peek(input logic [3:0] i);
        step(1'b0, 32'h0, 1'b0, i, 64'h0);
        @(posedge sys_clk);
        #1;
        chk("read_data", regs_m[i], read_data);
        chk("acc_read_data", {32'h0, accs_m[i[2:0]]}, {32'h0, acc_read_data});
    endtask

    // Offer one word for one cycle, check the decode answer, track state
    task automatic run(input logic [31:0] wd, input logic ok, input logic ae,
        input logic [63:0] fpv);
        logic [63:0] a;
        logic [31:0] p;
        logic [31:0] src;
        a = regs_m[wd[19:16]];
        p = a[31:0] * regs_m[wd[3:0]][31:0];
        src = wd[21] ? accs_m[wd[14:12]] : regs_m[wd[15:12]][31:0];
        step(1'b1, wd, 1'b0, 4'h0, 64'h0);
        cond_ok = ok;
        #1;
        chk("instr_accept", {63'h0, ok & ae}, {63'h0, instr_accept});
        chk("instr_undef", {63'h0, ok & ~ae}, {63'h0, instr_undef});
        if (ok && ae && wd[11:8] == GRP_ACC) begin
            accs_m[wd[7:5]] = wd[20] ? src - p : src + p;
        end else if (ok && ae) begin
            regs_m[wd[15:12]] = (wd[11:8] == GRP_FP) ? fpv :
                int_res({wd[21:20], wd[7:5]}, a, regs_m[wd[3:0]], regs_m[wd[15:12]]);
        end
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        give_verdict();
    end

    // Main sequence
    initial begin
        for (int i = 0; i < 16; i++) begin
            regs_m[i] = REG_RESET;
            accs_m[i[2:0]] = ACC_RESET;
        end
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        peek(4'hf);
        // Float cases, negative differences catch swapped operands
        for (int k = 0; k < 4; k++) begin
            load(4'h1, fa[k]);
            load(4'h3, fb[k]);
            run(mk(GRP_FP, fo[k][4:3], fo[k][2:0], 4'h1, 4'h2, 4'h3), 1'b1, 1'b1, fr[k]);
            peek(4'h2);
        end
        // Every integer code on the top register, with upper bits set
        load(4'h1, 64'hffffffff_80000000);
        load(4'h3, 64'h1);
        for (int k = 0; k < 12; k++) begin
            run(mk(GRP_INT, k < 8 ? SZ_ADDSUB : SZ_MUL, 3'(k), 4'h1, 4'hf, 4'h3), 1'b1, 1'b1, 64'h0);
            peek(4'hf);
        end
        // All accumulator forms back to back; the last two each read the previous result
        for (int k = 0; k < 4; k++) begin
            run(mk(GRP_ACC, 2'(k), 3'h7, 4'h1, 4'h7, 4'hf), 1'b1, 1'b1, 64'h0);
        end
        peek(4'h7);
        // Refused words and a failed condition leave all state alone
        run(mk(GRP_INT, SZ_ADDSUB, 3'h4, 4'h1, 4'h9, 4'h3) | 32'h10, 1'b1, 1'b0, 64'h0);
        run(mk(GRP_INT, SZ_ADDSUB, 3'h4, 4'h1, 4'h9, 4'h3) ^ 32'h01000000, 1'b1, 1'b0, 64'h0);
        run(mk(GRP_INT, SZ_ADDSUB, 3'h4, 4'h1, 4'h9, 4'h3) | 32'h00400000, 1'b1, 1'b0, 64'h0);
        run(mk(GRP_FP, SZ_ADDSUB, 3'h0, 4'h1, 4'h9, 4'h3), 1'b1, 1'b0, 64'h0);
        run(mk(GRP_INT, 2'h0, 3'h4, 4'h1, 4'h9, 4'h3), 1'b1, 1'b0, 64'h0);
        run(mk(GRP_ACC, 2'h0, 3'h1, 4'h1, 4'h9, 4'h3) | 32'h10, 1'b1, 1'b0, 64'h0);
        run(mk(GRP_INT, SZ_ADDSUB, 3'h4, 4'h1, 4'h9, 4'h3), 1'b0, 1'b1, 64'h0);
        peek(4'h9);
        // Random traffic across all integer and accumulator codes
        for (int k = 0; k < 150; k++) begin
            u = 4'($random(seed));
            n = 4'($random(seed));
            m = 4'($random(seed));
            d = 4'($random(seed));
            load(n, {$random(seed), $random(seed)});
            load(m, {$random(seed), $random(seed)});
            if (u < 8) begin
                w = mk(GRP_INT, SZ_ADDSUB, u[2:0], n, d, m);
            end else if (u < 12) begin
                w = mk(GRP_INT, SZ_MUL, {1'b0, u[1:0]}, n, d, m);
            end else begin
                w = mk(GRP_ACC, u[1:0], 3'($random(seed)), n, d, m);
            end
            run(w, 1'b1, 1'b1, 64'h0);
            peek(u < 12 ? d : {1'b0, w[7:5]});
        end
        // Reset in mid-run clears every register and accumulator
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 16; i++) begin
            regs_m[i] = REG_RESET;
            accs_m[i[2:0]] = ACC_RESET;
        end
        peek(4'h9);
        give_verdict();
    end
endmodule

// ---- host_issue_model.sv ----
// Host core model that offers coprocessor words to the decoder.
// Assumes the bench raises issue just after a falling clock edge.
`timescale 1ns/1ps
module host_issue_model (
    input  wire logic        sys_clk,     // Core clock
    input  wire logic        issue,       // Bench wants a word sent
    input  wire logic [31:0] word,        // Word to send
    input  wire logic        cond_ok,     // Condition flags satisfied
    output logic             instr_valid, // Offer to the decoder
    output logic [31:0]      instr        // Word on the port
);
    logic [31:0] last_q = 32'h5a5a5a5a;   // Last word shown on the port

    // Only words whose condition holds ever reach the coprocessor
    assign instr_valid = issue & cond_ok;
    // Idle port shows the inverse of the last word, never a stale copy
    assign instr = instr_valid ? word : ~last_q;

    // Remember what was shown so idle cycles keep changing
    always @(posedge sys_clk) begin
        last_q <= instr;
    end
endmodule
